/* File: rtl/slb_pkg.sv */
// shared constants for the serial line baud and framing block
package slb_pkg;
	// register word indices, byte address is index times four
	localparam logic [2:0] REG_BAUD_HIGH   = 3'h0;
	localparam logic [2:0] REG_BAUD_LOW    = 3'h1;
	localparam logic [2:0] REG_LINE_FORMAT = 3'h2;
	localparam logic [2:0] REG_ENABLE      = 3'h3;
	localparam logic [2:0] REG_STATUS      = 3'h4;
	localparam logic [2:0] REG_ACTIVITY    = 3'h5;
	localparam logic [2:0] REG_EXTRA       = 3'h6;
	localparam logic [2:0] REG_DATA        = 3'h7;
	// line format bit positions
	localparam int LF_LOOP   = 7;
	localparam int LF_FREEZE = 6;
	localparam int LF_RECEIVER_SOURCE_SELECT   = 5;
	localparam int LF_NINE   = 4;
	localparam int LF_WAKE   = 3;
	localparam int LF_ILT    = 2;
	localparam int LF_PE     = 1;
	localparam int LF_PT     = 0;
	// enable control bit positions
	localparam int EN_TE     = 3;
	localparam int EN_RE     = 2;
	localparam int EN_SLEEP  = 1;
	// status bit positions
	localparam int ST_TXEMPTY = 7;
	localparam int ST_TXDONE  = 6;
	localparam int ST_RXFULL  = 5;
	localparam int ST_IDLE    = 4;
	localparam int ST_OVERRUN = 3;
	localparam int ST_FRAMING = 1;
	localparam int ST_PARITY  = 0;
	// extra register bit positions
	localparam int EX_RX9    = 7;
	localparam int EX_TX9    = 6;
	localparam int EX_DIR    = 5;
	// reset values
	localparam logic [7:0] RST_BAUD_HIGH = 8'h00;
	localparam logic [7:0] RST_BAUD_LOW  = 8'h04;
	// oversampling and idle counts
	localparam logic [3:0] OVS_LAST   = 4'hF;
	localparam logic [3:0] OVS_MID    = 4'h7;
	localparam logic [3:0] IDLE_BITS8 = 4'hA;
	localparam logic [3:0] IDLE_BITS9 = 4'hB;
	localparam logic [3:0] BITS_8     = 4'hA;
	localparam logic [3:0] BITS_9     = 4'hB;
endpackage : slb_pkg

/* File: rtl/slb_baud_gen.sv */
// modulo divider giving the sixteen-times bit rate tick
`timescale 1ns/10ps
module slb_baud_gen #(
	parameter int WIDTH = 13
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             run_i,
	input  wire logic [WIDTH-1:0] div_i,
	output logic                  tick_o
);
	logic [WIDTH-1:0] cnt_r;

	// counter held at zero when stopped so nothing toggles
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r  <= '0;
			tick_o <= 1'b0;
		end else if (!run_i || div_i == '0) begin
			cnt_r  <= '0;
			tick_o <= 1'b0;
		end else if (cnt_r >= div_i - 1'b1) begin
			cnt_r  <= '0;
			tick_o <= 1'b1;
		end else begin
			cnt_r  <= cnt_r + 1'b1;
			tick_o <= 1'b0;
		end
	end
endmodule : slb_baud_gen

/* File: rtl/slb_serial.sv */
// serial line core: registers, baud control, framing, routing
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Function
// - eight byte registers on the bus
// - high divisor byte buffered until low write
// - generator idle until enable first set
// - zero divisor stops the generator
// - bit rate is clock over sixteen times divisor
// - loop select feeds transmitter or txd pin into receiver
// - loop clear gives two-pin full duplex
// - freeze bit stops clocks during wait
// - receiver source ignored without loop select
// - loop without source is internal loopback
// - loop with source is single-wire mode
// - eight or nine data bits, lsb first
// - wake condition from idle line or address mark; sleep bit not cleared by hardware
// - idle count starts after start or stop
// - parity generated and checked in msb
// - parity type selects even or odd
// - direction bit steers single-wire pin
// - loop mode releases receive pin
module slb_serial
	import slb_pkg::*;
(
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	input  wire logic [4:0]  ADDRESS_I,
	input  wire logic        READ_I,
	input  wire logic        WRITE_I,
	input  wire logic [3:0]  BYTEENABLE_I,
	input  wire logic [31:0] WRITEDATA_I,
	output logic      [31:0] READDATA_O,
	output logic             WAITREQUEST_O,
	input  wire logic        WAIT_MODE_I,
	input  wire logic        RXD_I,
	input  wire logic        TXD_I,
	output logic             TXD_O,
	output logic             TXD_OE_N_O,
	output logic             RXD_OWNED_O
);
	typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} slb_tx_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} slb_rx_t;

	//////////////////////////////////////////////////////////////////////////
	// register storage
	logic [7:0]  high_buf_r;
	logic [7:0]  low_r;
	logic [12:0] divisor_r;
	logic [7:0]  fmt_r;
	logic [7:0]  en_r;
	logic        dir_r;
	logic        tx9_r;
	logic        started_r;
	logic        tx_empty_r;
	logic        tx_done_r;
	logic        rx_full_r;
	logic        idle_r;
	logic        overrun_r;
	logic        frame_err_r;
	logic        par_err_r;
	logic [8:0]  tx_hold_r;
	logic [8:0]  rx_data_r;
	logic        rx_active_r;

	// bus access strobes, taken on the edge where waitrequest is low
	logic        acc_wr;
	logic        acc_rd;
	logic [2:0]  idx;
	logic [7:0]  wbyte;
	assign idx    = ADDRESS_I[4:2];
	assign wbyte  = WRITEDATA_I[7:0];
	assign acc_wr = WRITE_I && !WAITREQUEST_O && BYTEENABLE_I[0];
	assign acc_rd = READ_I && !WAITREQUEST_O;

	//////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait state, read data registered
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		case (idx)
			REG_BAUD_HIGH:   rd_mux = {3'h0, high_buf_r[4:0]};
			REG_BAUD_LOW:    rd_mux = low_r;
			REG_LINE_FORMAT: rd_mux = fmt_r;
			REG_ENABLE:      rd_mux = en_r;
			REG_STATUS:      rd_mux = {tx_empty_r, tx_done_r, rx_full_r, idle_r,
				overrun_r, 1'b0, frame_err_r, par_err_r};
			REG_ACTIVITY:    rd_mux = {7'h00, rx_active_r};
			REG_EXTRA:       rd_mux = {rx_data_r[8], tx9_r, dir_r, 5'h00};
			REG_DATA:        rd_mux = rx_data_r[7:0];
			default:         rd_mux = 8'h00;
		endcase
	end

	// waitrequest drops for exactly one cycle per request
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			WAITREQUEST_O <= 1'b1;
			READDATA_O    <= 32'h0000_0000;
		end else if ((READ_I || WRITE_I) && WAITREQUEST_O) begin
			WAITREQUEST_O <= 1'b0;
			READDATA_O    <= {24'h000000, rd_mux};
		end else begin
			WAITREQUEST_O <= 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// divisor: high byte only buffered, whole value moves on low write
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			high_buf_r <= RST_BAUD_HIGH;
			low_r      <= RST_BAUD_LOW;
			divisor_r  <= {RST_BAUD_HIGH[4:0], RST_BAUD_LOW};
		end else if (acc_wr && idx == REG_BAUD_HIGH) begin
			high_buf_r <= {3'h0, wbyte[4:0]};
		end else if (acc_wr && idx == REG_BAUD_LOW) begin
			low_r      <= wbyte;
			divisor_r  <= {high_buf_r[4:0], wbyte};
		end
	end

	// control registers
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			fmt_r <= 8'h00;
			en_r  <= 8'h00;
			dir_r <= 1'b0;
			tx9_r <= 1'b0;
		end else if (acc_wr) begin
			if (idx == REG_LINE_FORMAT)
				fmt_r <= wbyte;
			if (idx == REG_ENABLE)
				en_r <= {4'h0, wbyte[EN_TE], wbyte[EN_RE], wbyte[EN_SLEEP], 1'b0};
			if (idx == REG_EXTRA) begin
				dir_r <= wbyte[EX_DIR];
				tx9_r <= wbyte[EX_TX9];
			end
		end
	end

	// generator stays parked after reset until an enable is written to one
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I)
			started_r <= 1'b0;
		else if (acc_wr && idx == REG_ENABLE && (wbyte[EN_TE] || wbyte[EN_RE]))
			started_r <= 1'b1;
	end

	//////////////////////////////////////////////////////////////////////////
	// baud generator with wait-mode freeze
	logic tick;
	logic freeze;
	assign freeze = fmt_r[LF_FREEZE] && WAIT_MODE_I;

	slb_baud_gen #(
		.WIDTH (13)
	) u_baud (
		.clk_i  (CLK_I),
		.rst_i  (RST_I),
		.run_i  (started_r && !freeze),
		.div_i  (divisor_r),
		.tick_o (tick)
	);

	//////////////////////////////////////////////////////////////////////////
	// pin synchronisers, two flops each
	logic [1:0] rxd_sync_r;
	logic [1:0] txd_sync_r;
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rxd_sync_r <= 2'b11;
			txd_sync_r <= 2'b11;
		end else begin
			rxd_sync_r <= {rxd_sync_r[0], RXD_I};
			txd_sync_r <= {txd_sync_r[0], TXD_I};
		end
	end

	// receiver source routing
	logic loop_m;
	logic single_m;
	logic tx_line;
	logic rx_line;
	assign loop_m   = fmt_r[LF_LOOP];
	assign single_m = loop_m && fmt_r[LF_RECEIVER_SOURCE_SELECT];
	always_comb begin
		if (!loop_m)
			rx_line = rxd_sync_r[1];
		else if (single_m)
			rx_line = txd_sync_r[1];
		else
			rx_line = tx_line;
	end

	//////////////////////////////////////////////////////////////////////////
	// parity helpers: msb replaced by parity of lower bits
	logic nine;
	logic [8:0] tx_word;
	assign nine = fmt_r[LF_NINE];
	always_comb begin
		tx_word = {tx9_r, tx_hold_r[7:0]};
		if (fmt_r[LF_PE]) begin
			if (nine)
				tx_word[8] = (^tx_hold_r[7:0]) ^ fmt_r[LF_PT];
			else
				tx_word[7] = (^tx_hold_r[6:0]) ^ fmt_r[LF_PT];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// transmitter: start, 8 or 9 data bits lsb first, stop
	slb_tx_t     tx_st_r;
	logic [10:0] tx_sh_r;
	logic [3:0]  tx_ovs_r;
	logic [3:0]  tx_cnt_r;
	logic        tx_out_r;
	assign tx_line = tx_out_r;

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			tx_st_r  <= TX_IDLE;
			tx_sh_r  <= 11'h7FF;
			tx_ovs_r <= 4'h0;
			tx_cnt_r <= 4'h0;
			tx_out_r <= 1'b1;
		end else if (tick) begin
			case (tx_st_r)
				TX_IDLE: begin
					tx_out_r <= 1'b1;
					if (en_r[EN_TE] && !tx_empty_r) begin
						tx_sh_r  <= nine ? {1'b1, tx_word, 1'b0}
							: {2'b11, tx_word[7:0], 1'b0};
						tx_cnt_r <= nine ? BITS_9 : BITS_8;
						tx_ovs_r <= 4'h0;
						tx_st_r  <= TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					tx_out_r <= tx_sh_r[0];
					tx_ovs_r <= tx_ovs_r + 4'h1;
					if (tx_ovs_r == OVS_LAST) begin
						tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
						tx_cnt_r <= tx_cnt_r - 4'h1;
						if (tx_cnt_r == 4'h1)
							tx_st_r <= TX_IDLE;
					end
				end
				default: tx_st_r <= TX_IDLE;
			endcase
		end
	end

	// holding register and its flags; hardware set beats software clear
	logic tx_load;
	assign tx_load = tick && tx_st_r == TX_IDLE && en_r[EN_TE] && !tx_empty_r;
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			tx_hold_r  <= 9'h000;
			tx_empty_r <= 1'b1;
			tx_done_r  <= 1'b1;
		end else begin
			if (tx_load)
				tx_empty_r <= 1'b1;
			else if (acc_wr && idx == REG_DATA)
				tx_empty_r <= 1'b0;
			if (acc_wr && idx == REG_DATA)
				tx_hold_r <= {1'b0, wbyte};
			if (tx_load)
				tx_done_r <= 1'b0;
			else if (tick && tx_st_r == TX_IDLE && tx_empty_r)
				tx_done_r <= 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// receiver: falling edge of idle-high line, mid-bit sampling
	slb_rx_t     rx_st_r;
	logic [3:0]  rx_ovs_r;
	logic [3:0]  rx_cnt_r;
	logic [9:0]  rx_sh_r;
	logic        rx_prev_r;
	logic        rx_end;
	logic        rx_sample;
	assign rx_sample = tick && rx_ovs_r == OVS_LAST;

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rx_st_r   <= RX_IDLE;
			rx_ovs_r  <= 4'h0;
			rx_cnt_r  <= 4'h0;
			rx_sh_r   <= 10'h000;
			rx_prev_r <= 1'b1;
		end else if (tick) begin
			rx_prev_r <= rx_line;
			case (rx_st_r)
				RX_IDLE: begin
					if (en_r[EN_RE] && rx_prev_r && !rx_line) begin
						rx_ovs_r <= 4'h0;
						rx_st_r  <= RX_START;
					end
				end
				RX_START: begin
					rx_ovs_r <= rx_ovs_r + 4'h1;
					if (rx_ovs_r == OVS_MID) begin
						rx_ovs_r <= 4'h0;
						rx_cnt_r <= (nine ? BITS_9 : BITS_8) - 4'h1;
						rx_st_r  <= rx_line ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					rx_ovs_r <= rx_ovs_r + 4'h1;
					if (rx_ovs_r == OVS_LAST) begin
						rx_sh_r  <= {rx_line, rx_sh_r[9:1]};
						rx_cnt_r <= rx_cnt_r - 4'h1;
						if (rx_cnt_r == 4'h1)
							rx_st_r <= RX_IDLE;
					end
				end
				default: rx_st_r <= RX_IDLE;
			endcase
		end
	end
	assign rx_end = rx_sample && rx_st_r == RX_DATA && rx_cnt_r == 4'h1;

	// align the received bits: last shifted is the top data bit, the stop bit is still on rx_line
	logic [8:0] rx_word;
	logic       rx_stop;
	logic       rx_msb;
	logic       rx_par_bad;
	always_comb begin
		rx_stop = rx_line;
		if (nine)
			rx_word = rx_sh_r[9:1];
		else
			rx_word = {1'b0, rx_sh_r[9:2]};
		rx_msb = nine ? rx_word[8] : rx_word[7];
		// count of ones including parity must match the type
		rx_par_bad = fmt_r[LF_PE] && ((^rx_word) != fmt_r[LF_PT]);
	end

	//////////////////////////////////////////////////////////////////////////
	// idle line counter, in bit times of high level
	logic [3:0] idle_cnt_r;
	logic [3:0] idle_ovs_r;
	logic       idle_armed_r;
	logic       idle_hit;
	assign idle_hit = idle_cnt_r == (nine ? IDLE_BITS9 : IDLE_BITS8);

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			idle_cnt_r <= 4'h0;
			idle_ovs_r <= 4'h0;
		end else if (tick) begin
			idle_ovs_r <= idle_ovs_r + 4'h1;
			if (!rx_line || rx_st_r == RX_START)
				idle_cnt_r <= 4'h0; // ilt clear: count starts after start bit
			else if (fmt_r[LF_ILT] && rx_st_r != RX_IDLE)
				idle_cnt_r <= 4'h0;
			else if (idle_ovs_r == OVS_LAST && !idle_hit)
				idle_cnt_r <= idle_cnt_r + 4'h1;
		end
	end

	// receiver sleep: idle-line or address-mark wake
	logic asleep;
	logic wake_now;
	assign asleep = en_r[EN_SLEEP];
	assign wake_now = fmt_r[LF_WAKE] ? (rx_end && rx_msb) : idle_hit;

	//////////////////////////////////////////////////////////////////////////
	// receive flags; a hardware set in the clearing cycle wins
	logic rx_take;
	logic st_clr;
	assign rx_take = rx_end && (!asleep || (fmt_r[LF_WAKE] && rx_msb));
	assign st_clr  = acc_wr && idx == REG_STATUS;

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rx_data_r    <= 9'h000;
			rx_full_r    <= 1'b0;
			overrun_r    <= 1'b0;
			frame_err_r  <= 1'b0;
			par_err_r    <= 1'b0;
			idle_r       <= 1'b0;
			idle_armed_r <= 1'b0;
		end else begin
			if (rx_take && !rx_full_r)
				rx_data_r <= rx_word;
			if (rx_take)
				rx_full_r <= 1'b1;
			else if (acc_rd && idx == REG_DATA)
				rx_full_r <= 1'b0;
			if (rx_take && rx_full_r)
				overrun_r <= 1'b1;
			else if (st_clr && wbyte[ST_OVERRUN])
				overrun_r <= 1'b0;
			if (rx_take && !rx_stop)
				frame_err_r <= 1'b1;
			else if (st_clr && wbyte[ST_FRAMING])
				frame_err_r <= 1'b0;
			if (rx_take && rx_par_bad)
				par_err_r <= 1'b1;
			else if (st_clr && wbyte[ST_PARITY])
				par_err_r <= 1'b0;
			// idle reported once per gap after a character
			if (rx_end)
				idle_armed_r <= 1'b1;
			else if (idle_hit && idle_armed_r)
				idle_armed_r <= 1'b0;
			if (idle_hit && idle_armed_r && !asleep)
				idle_r <= 1'b1;
			else if (st_clr && wbyte[ST_IDLE])
				idle_r <= 1'b0;
		end
	end

	// sleep bit is not cleared by hardware on wake; wake_r is only recorded
	logic wake_r;
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I)
			wake_r <= 1'b0;
		else
			wake_r <= asleep && wake_now;
	end

	// receiver busy indication
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I)
			rx_active_r <= 1'b0;
		else
			rx_active_r <= rx_st_r != RX_IDLE;
	end

	//////////////////////////////////////////////////////////////////////////
	// pin ownership, registered outputs
	logic tx_busy;
	assign tx_busy = tx_st_r != TX_IDLE || !tx_empty_r;
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			TXD_O       <= 1'b1;
			TXD_OE_N_O  <= 1'b1;
			RXD_OWNED_O <= 1'b0;
		end else begin
			TXD_O <= tx_out_r;
			// outside single-wire mode a disabled transmitter keeps the pin while a frame runs or a character waits in the holding register
			if (single_m)
				TXD_OE_N_O <= !dir_r;
			else
				TXD_OE_N_O <= !(en_r[EN_TE] || tx_busy);
			RXD_OWNED_O <= en_r[EN_RE] && !loop_m;
		end
	end

	// unused high write lanes are ignored; wake_r is recorded but drives nothing
	logic unused_ok;
	assign unused_ok = wake_r;
endmodule : slb_serial

/* File: tb/slb_serial_properties.sv */
// checker for the serial line block ports
`timescale 1ns/10ps
module slb_serial_properties
	import slb_pkg::*;
(
	input wire logic        CLK_I,
	input wire logic        RST_I,
	input wire logic [4:0]  ADDRESS_I,
	input wire logic        READ_I,
	input wire logic        WRITE_I,
	input wire logic [3:0]  BYTEENABLE_I,
	input wire logic [31:0] WRITEDATA_I,
	input wire logic [31:0] READDATA_O,
	input wire logic        WAITREQUEST_O,
	input wire logic        WAIT_MODE_I,
	input wire logic        RXD_I,
	input wire logic        TXD_I,
	input wire logic        TXD_O,
	input wire logic        TXD_OE_N_O,
	input wire logic        RXD_OWNED_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	logic        acc, sw_on, tx_q_r;
	logic [7:0]  hi_r, lf_r, en_r, ex_r;
	logic [12:0] div_r;
	logic [17:0] gap_r;
	// accepted write on the low byte lane
	assign acc = WRITE_I && !WAITREQUEST_O && BYTEENABLE_I[0];
	assign sw_on = lf_r[LF_LOOP] && lf_r[LF_RECEIVER_SOURCE_SELECT] && en_r[EN_TE];
	// shadow of what software last wrote
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			hi_r <= 8'h00;
			div_r <= {5'h00, RST_BAUD_LOW};
			lf_r <= 8'h00;
			en_r <= 8'h00;
			ex_r <= 8'h00;
		end else if (acc) begin
			case (ADDRESS_I[4:2])
				REG_BAUD_HIGH: hi_r <= WRITEDATA_I[7:0];
				REG_BAUD_LOW: div_r <= {hi_r[4:0], WRITEDATA_I[7:0]};
				REG_LINE_FORMAT: lf_r <= WRITEDATA_I[7:0];
				REG_ENABLE: en_r <= WRITEDATA_I[7:0];
				REG_EXTRA: ex_r <= WRITEDATA_I[7:0];
				default: ;
			endcase
		end
	end
	// cycles since the line last moved; saturates so idle never wraps
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			tx_q_r <= 1'b1;
			gap_r <= '1;
		end else begin
			tx_q_r <= TXD_O;
			gap_r <= (TXD_O != tx_q_r) ? 18'h00001 : ((gap_r == '1) ? gap_r : gap_r + 18'h00001);
		end
	end
	//////////////////////////////////////////////////////////////////////
	// registered outputs lag a write by one cycle, hence two quiet edges
	sequence quiet;
		(!acc) [*2];
	endsequence
	sequence frozen;
		(lf_r[LF_FREEZE] && WAIT_MODE_I) [*4];
	endsequence
	sequence stopped;
		(div_r == 13'h0000) [*3];
	endsequence
	a_wait_once: assert property ($rose(READ_I || WRITE_I) |=> !WAITREQUEST_O)
		else $error("request not answered after one wait cycle");
	a_wait_pulse: assert property (!WAITREQUEST_O |=> WAITREQUEST_O)
		else $error("waitrequest low for more than one cycle");
	a_read_width: assert property (READ_I && !WAITREQUEST_O |-> READDATA_O[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	a_rx_owned: assert property (quiet |-> RXD_OWNED_O == (en_r[EN_RE] && !lf_r[LF_LOOP]))
		else $error("receive pin ownership wrong");
	a_single_dir: assert property (quiet ##0 sw_on |-> TXD_OE_N_O == !ex_r[EX_DIR])
		else $error("single-wire pin direction wrong");
	a_freeze_hold: assert property (frozen |-> $stable(TXD_O))
		else $error("line moved while frozen in wait");
	a_zero_still: assert property (stopped |-> $stable(TXD_O))
		else $error("line moved with divisor zero");
	a_bit_spacing: assert property (TXD_O != tx_q_r |-> gap_r >= {1'b0, div_r, 4'h0})
		else $error("bit shorter than sixteen divisor cycles");
endmodule : slb_serial_properties

/* File: tb/slb_line_partner.sv */
// line-side transceiver model for the serial line block
`timescale 1ns/10ps
module slb_line_partner (
	input  wire logic        clk_i,
	input  wire logic        line_i,
	input  wire logic        nine_i,
	input  wire logic [15:0] bitc_i,
	output logic             tx_o,
	output logic [9:0]       got_o,
	output logic             got_v_o
);
	// idle high from the start
	initial begin
		tx_o = 1'b1;
		got_v_o = 1'b0;
	end
	// start, data lsb first, stop
	task automatic send(input logic [8:0] d);
		tx_o <= 1'b0;
		repeat (bitc_i) @(posedge clk_i);
		for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
			tx_o <= d[i];
			repeat (bitc_i) @(posedge clk_i);
		end
		tx_o <= 1'b1;
		repeat (bitc_i) @(posedge clk_i);
	endtask : send
	// mid-bit sampling; a short stop bit shows in bit 9
	always begin
		@(negedge line_i);
		got_o = 10'h000;
		repeat (bitc_i / 2) @(posedge clk_i);
		for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
			repeat (bitc_i) @(posedge clk_i);
			got_o[i] = line_i;
		end
		repeat (bitc_i) @(posedge clk_i);
		got_o[9] = line_i;
		got_v_o <= 1'b1;
		@(posedge clk_i);
		got_v_o <= 1'b0;
	end
endmodule : slb_line_partner

/* File: tb/test_slb_serial.sv */
// self-checking bench for the serial line block
`timescale 1ns/10ps
module test_slb_serial
	import slb_pkg::*;
	;
	logic        clk, rst, rd, wr, wmode, txd, oe_n, owned, wreq, nine, hear, sw, got_v, p_tx, line;
	logic [4:0]  addr;
	logic [3:0]  be;
	logic [15:0] bitc;
	logic [31:0] wdata, rdata;
	logic [9:0]  got;
	logic [8:0]  d;
	logic [2:0]  m;
	logic [7:0]  rq[$];
	logic [9:0]  fq[$];
	int          error_cnt, checks, cyc, seed;
	// released pin rests high; in single-wire runs the far end drives it
	assign line = (oe_n === 1'b0) ? txd : (sw ? p_tx : 1'b1);
	slb_serial dut_u (.CLK_I(clk), .RST_I(rst), .ADDRESS_I(addr), .READ_I(rd), .WRITE_I(wr),
		.BYTEENABLE_I(be), .WRITEDATA_I(wdata), .READDATA_O(rdata), .WAITREQUEST_O(wreq),
		.WAIT_MODE_I(wmode), .RXD_I(p_tx), .TXD_I(line), .TXD_O(txd), .TXD_OE_N_O(oe_n), .RXD_OWNED_O(owned));
	slb_line_partner part_u (.clk_i(clk), .line_i(line), .nine_i(nine), .bitc_i(bitc), .tx_o(p_tx),
		.got_o(got), .got_v_o(got_v));
	//////////////////////////////////////////////////////////////////////
	task automatic bus(input logic w, input logic [2:0] idx, input logic [7:0] v);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= {idx, 2'b00};
		wdata <= {24'h000000, v};
		do @(posedge clk); while (wreq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic rdx(input logic [2:0] idx, input logic [7:0] e);
		rq.push_back(e);
		bus(1'b0, idx, 8'h00);
	endtask : rdx
	task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask : cmp_byte
	task automatic cmp_frame(input logic [9:0] g, input logic [9:0] e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask : cmp_frame
	// character as it must appear, parity folded into the top data bit
	function automatic logic [8:0] frame(input logic [8:0] v, input logic [2:0] f);
		logic [8:0] c;
		c = f[2] ? v : {1'b0, v[7:0]};
		if (f[1]) begin
			c[f[2] ? 8 : 7] = 1'b0;
			c[f[2] ? 8 : 7] = (^c) ^ f[0];
		end
		return c;
	endfunction : frame
	task automatic txf(input logic [8:0] v, input logic [2:0] f);
		fq.push_back({1'b1, frame(v, f)});
		bus(1'b1, REG_EXTRA, {1'b0, v[8], 6'h00});
		bus(1'b1, REG_DATA, v[7:0]);
	endtask : txf
	task automatic drain();
		wait (fq.size() == 0);
		repeat (bitc) @(posedge clk);
	endtask : drain
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run
	//////////////////////////////////////////////////////////////////////
	// clock, and a hang guard well above the expected run
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			complete_run();
		end
	end
	// results meet the oldest note; frames heard in loop tests are ignored
	always @(posedge clk) begin
		if (rd && !wreq) cmp_byte(rdata[7:0], rq.pop_front());
		if (got_v && hear) cmp_frame(got, fq.pop_front());
	end
	initial begin
		seed = 70136;
		{rst, be, bitc} = {1'b1, 4'hF, 16'h0020};
		{rd, wr, wmode, nine, sw, hear, addr, wdata} = {6'h01, 5'h00, 32'h0};
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rdx(REG_BAUD_LOW, RST_BAUD_LOW);
		rdx(REG_LINE_FORMAT, 8'h00);
		rdx(REG_STATUS, 8'hC0);
		be <= 4'h0;
		bus(1'b1, REG_LINE_FORMAT, 8'hFF);
		be <= 4'hF;
		rdx(REG_LINE_FORMAT, 8'h00);
		// high byte waits for the low write
		bus(1'b1, REG_BAUD_LOW, 8'h02);
		bus(1'b1, REG_BAUD_HIGH, 8'h01);
		rdx(REG_BAUD_HIGH, 8'h01);
		bus(1'b1, REG_ENABLE, 8'h0C);
		txf(9'h0A5, 3'h0);
		drain();
		bus(1'b1, REG_BAUD_HIGH, 8'h00);
		bus(1'b1, REG_BAUD_LOW, 8'h02);
		$display("test divisor done");
		// every length and parity mix, receiver source toggled at random
		for (int i = 0; i < 8; i++) begin
			m = 3'(i);
			nine <= m[2];
			bus(1'b1, REG_LINE_FORMAT, {2'b00, 1'($random(seed)), m[2], 2'b00, m[1:0]});
			txf(9'($random(seed)), m);
			drain();
			d = frame(9'($random(seed)), m);
			part_u.send(d);
			rdx(REG_DATA, d[7:0]);
		end
		$display("test formats done");
		// internal loop: pin traffic must not reach the receiver
		hear <= 1'b0;
		nine <= 1'b0;
		bus(1'b1, REG_LINE_FORMAT, 8'h80);
		repeat (3) @(posedge clk);
		cmp_byte({7'h00, owned}, 8'h00);
		d = 9'($random(seed)) & 9'h0FF;
		fork
			bus(1'b1, REG_DATA, d[7:0]);
			part_u.send(~d);
		join
		repeat (64) @(posedge clk);
		rdx(REG_DATA, d[7:0]);
		$display("test loop done");
		// single wire: direction bit steers the shared pin
		bus(1'b1, REG_LINE_FORMAT, 8'hA0);
		bus(1'b1, REG_EXTRA, 8'h20);
		repeat (3) @(posedge clk);
		cmp_byte({7'h00, oe_n}, 8'h00);
		bus(1'b1, REG_EXTRA, 8'h00);
		repeat (3) @(posedge clk);
		cmp_byte({7'h00, oe_n}, 8'h01);
		sw <= 1'b1;
		d = 9'($random(seed)) & 9'h0FF;
		part_u.send(d);
		rdx(REG_DATA, d[7:0]);
		sw <= 1'b0;
		hear <= 1'b1;
		$display("test single wire done");
		// frames pause while frozen in wait or with a zero divisor
		bus(1'b1, REG_LINE_FORMAT, 8'h40);
		wmode <= 1'b1;
		txf(9'h03C, 3'h0);
		repeat (400) @(posedge clk);
		cmp_byte({7'h00, txd}, 8'h01);
		wmode <= 1'b0;
		drain();
		bus(1'b1, REG_BAUD_LOW, 8'h00);
		txf(9'h0C3, 3'h0);
		repeat (400) @(posedge clk);
		cmp_byte({7'h00, txd}, 8'h01);
		bus(1'b1, REG_BAUD_LOW, 8'h02);
		drain();
		$display("test pause done");
		// even parity, one set bit: parity error, then idle after ten quiet bits
		bus(1'b1, REG_LINE_FORMAT, 8'h02);
		bus(1'b1, REG_STATUS, 8'h1B);
		part_u.send(9'h001);
		repeat (384) @(posedge clk);
		rdx(REG_STATUS, 8'hF1);
		rdx(REG_DATA, 8'h01);
		$display("test flags done");
		complete_run();
	end
endmodule : test_slb_serial
bind slb_serial slb_serial_properties chk_u (.CLK_I(CLK_I), .RST_I(RST_I), .ADDRESS_I(ADDRESS_I),
	.READ_I(READ_I), .WRITE_I(WRITE_I), .BYTEENABLE_I(BYTEENABLE_I), .WRITEDATA_I(WRITEDATA_I),
	.READDATA_O(READDATA_O), .WAITREQUEST_O(WAITREQUEST_O), .WAIT_MODE_I(WAIT_MODE_I), .RXD_I(RXD_I),
	.TXD_I(TXD_I), .TXD_O(TXD_O), .TXD_OE_N_O(TXD_OE_N_O), .RXD_OWNED_O(RXD_OWNED_O));
